/* core/rpc_defines.svh */
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH
// Clock rate and time pulse timing
`define RPC_CLK_HZ      250000000
`define RPC_PULSE_HZ    1
`define RPC_PERIOD_CYC  (`RPC_CLK_HZ / `RPC_PULSE_HZ)
`define RPC_PW_NS       4200
`define RPC_PW_CYC      ((`RPC_PW_NS * (`RPC_CLK_HZ / 1000000)) / 1000)
`define RPC_RPT_MS      500
`define RPC_RPT_CYC     (`RPC_RPT_MS * (`RPC_CLK_HZ / 1000))
// Serial port defaults
`define RPC_BAUD_A      38400
`define RPC_BAUD_B      4800
`define RPC_DIV_A       (`RPC_CLK_HZ / `RPC_BAUD_A)
`define RPC_DIV_B       (`RPC_CLK_HZ / `RPC_BAUD_B)
// Register byte offsets
`define RPC_OFF_CTRL    8'h00
`define RPC_OFF_PW      8'h04
`define RPC_OFF_CDLY    8'h08
`define RPC_OFF_DIVA    8'h0C
`define RPC_OFF_DIVB    8'h10
`define RPC_OFF_STAT    8'h14
`define RPC_OFF_IST     8'h18
`define RPC_OFF_IMSK    8'h1C
`define RPC_OFF_TXA     8'h20
`define RPC_OFF_TXB     8'h24
`define RPC_OFF_RXA     8'h28
`define RPC_OFF_RXB     8'h2C
`define RPC_OFF_SECS    8'h30
// Control fields and reset value
`define RPC_CTRL_POL    0
`define RPC_CTRL_FIX    1
`define RPC_CTRL_MODE   4
`define RPC_CTRL_PRA    8
`define RPC_CTRL_PRB    10
`define RPC_CTRL_RST    32'h0000_0800
// Interrupt status bits
`define RPC_IRQ_PULSE   0
`define RPC_IRQ_RXA     1
`define RPC_IRQ_RXB     2
`define RPC_IRQ_ANT     3
// Status fields
`define RPC_STAT_SBY    2
`define RPC_STAT_TXA    3
`endif

/* core/rpc_pkg.sv */
package rpc_pkg;
   typedef enum logic [1:0] {ANT_OPEN, ANT_NORMAL, ANT_SHORT, ANT_UNDEF} rpc_ant_t;
   typedef enum logic [1:0] {PROTO_BIN, PROTO_ASCII, PROTO_NAV} rpc_proto_t;
   typedef enum logic [1:0] {PM_ALWAYS, PM_FIX_ONLY, PM_OFF} rpc_pmode_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rpc_rx_st_t;
endpackage

/* core/rpc_top.sv */
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rpc_defines.svh"
module rpc_top #(
   parameter int PERIOD    = `RPC_PERIOD_CYC,
   parameter int RPT_LIMIT = `RPC_RPT_CYC
) (
   input  logic             clk,
   input  logic             rst_b,
   input  logic [7:0]       s_axi_awaddr,
   input  logic             s_axi_awvalid,
   output logic             s_axi_awready,
   input  logic [31:0]      s_axi_wdata,
   input  logic [3:0]       s_axi_wstrb,
   input  logic             s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  logic             s_axi_bready,
   input  logic [7:0]       s_axi_araddr,
   input  logic             s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  logic             s_axi_rready,
   input  logic             hw_reset_n,
   input  logic             run_not_sleep,
   input  logic             ant_ovc_sense,
   input  logic             ant_noc_sense,
   output logic             ext_amp_power_off,
   output logic             one_hz_time_pulse,
   output rpc_pkg::rpc_ant_t ant_status,
   input  logic             rxd_a,
   output logic             txd_a,
   input  logic             rxd_b,
   output logic             txd_b,
   output logic             irq
);
   import rpc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic [1:0]  hw_q_r;
   logic        rst_core_b;
   logic [1:0]  run_q_r;
   logic [1:0]  ovc_q_r;
   logic [1:0]  noc_q_r;
   logic        run_r;
   rpc_ant_t    ant_r;
   rpc_ant_t    ant_nxt;
   logic [31:0] ctrl_r;
   logic [27:0] pw_r;
   logic [27:0] cdly_r;
   logic [15:0] div_r [2];
   logic [3:0]  ist_r;
   logic [3:0]  imsk_r;
   logic [3:0]  ist_set;
   logic [3:0]  ist_clr;
   logic [31:0] wm;
   logic        wr_en;
   logic        wr_hit;
   logic [31:0] rd_nxt;
   logic        rd_hit;
   logic [27:0] sec_cnt_r;
   logic [28:0] win_end;
   logic        pulse_en;
   logic        act_nxt;
   logic        act_r;
   logic        pulse_rise;
   logic [31:0] secs_r;
   logic        rpt_pend_r;
   logic [26:0] rpt_age_r;
   logic        rpt_go;
   logic        wr_tx [2];
   logic        tx_load [2];
   logic [7:0]  tx_byte [2];
   logic [9:0]  tsh_r [2];
   logic [3:0]  tbit_r [2];
   logic [15:0] tcnt_r [2];
   logic        tbusy_r [2];
   logic [1:0]  rxq_r [2];
   rpc_rx_st_t  rxs_r [2];
   logic [15:0] rcnt_r [2];
   logic [2:0]  rbit_r [2];
   logic [7:0]  rsh_r [2];
   logic [7:0]  rx_data_r [2];
   logic        rx_evt_r [2];

   ////////////////////////////////////////////////////////////////////
   // Reset pin synchronised, then merged into the core reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hw_q_r <= 2'h0;
      end else begin
         hw_q_r <= {hw_q_r[0], hw_reset_n};
      end
   end
   // Whole device restarts while the pin is low
   assign rst_core_b = rst_b & hw_q_r[1];

   // Run and antenna pins settle through two stages
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         run_q_r <= 2'h0;
         ovc_q_r <= 2'h3;
         noc_q_r <= 2'h3;
      end else begin
         run_q_r <= {run_q_r[0], run_not_sleep};
         ovc_q_r <= {ovc_q_r[0], ant_ovc_sense};
         noc_q_r <= {noc_q_r[0], ant_noc_sense};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Antenna truth table; an unpowered sense line idles high (open)
   always_comb begin
      case ({ovc_q_r[1], noc_q_r[1]})
         2'b11:   ant_nxt = ANT_OPEN;
         2'b10:   ant_nxt = ANT_NORMAL;
         2'b00:   ant_nxt = ANT_SHORT;
         default: ant_nxt = ANT_UNDEF;
      endcase
   end

   // Standby state and amplifier switch
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         run_r             <= 1'b0;
         ext_amp_power_off <= 1'b1;
         ant_r             <= ANT_OPEN;
      end else begin
         run_r             <= run_q_r[1];
         ext_amp_power_off <= ~run_q_r[1];
         ant_r             <= ant_nxt;
      end
   end
   assign ant_status = ant_r;

   ////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken together
   assign wr_en         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_en;
   assign s_axi_wready  = wr_en;
   assign wm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign wr_hit = (s_axi_awaddr <= `RPC_OFF_SECS) && (s_axi_awaddr[1:0] == 2'h0);
   assign wr_tx[0] = wr_en && s_axi_awaddr == `RPC_OFF_TXA && s_axi_wstrb[0];
   assign wr_tx[1] = wr_en && s_axi_awaddr == `RPC_OFF_TXB && s_axi_wstrb[0];
   assign ist_clr = (wr_en && s_axi_awaddr == `RPC_OFF_IST) ? (s_axi_wdata[3:0] & wm[3:0])
                                                            : 4'h0;

   // Software settings, byte lanes honoured
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         ctrl_r   <= `RPC_CTRL_RST;
         pw_r     <= 28'(`RPC_PW_CYC);
         cdly_r   <= 28'h000_0000;
         div_r[0] <= 16'(`RPC_DIV_A);
         div_r[1] <= 16'(`RPC_DIV_B);
         imsk_r   <= 4'h0;
      end else if (wr_en) begin
         case (s_axi_awaddr)
            `RPC_OFF_CTRL: ctrl_r <= (ctrl_r & ~wm) | (s_axi_wdata & wm);
            `RPC_OFF_PW:   pw_r   <= (pw_r & ~wm[27:0]) | (s_axi_wdata[27:0] & wm[27:0]);
            `RPC_OFF_CDLY: cdly_r <= (cdly_r & ~wm[27:0]) | (s_axi_wdata[27:0] & wm[27:0]);
            `RPC_OFF_DIVA: div_r[0] <= (div_r[0] & ~wm[15:0]) | (s_axi_wdata[15:0] & wm[15:0]);
            `RPC_OFF_DIVB: div_r[1] <= (div_r[1] & ~wm[15:0]) | (s_axi_wdata[15:0] & wm[15:0]);
            `RPC_OFF_IMSK: imsk_r <= (imsk_r & ~wm[3:0]) | (s_axi_wdata[3:0] & wm[3:0]);
            default: ;
         endcase
      end
   end

   // Write response, error for unmapped words
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_nxt = 32'h0000_0000;
      case (s_axi_araddr)
         `RPC_OFF_CTRL: rd_nxt = ctrl_r;
         `RPC_OFF_PW:   rd_nxt = {4'h0, pw_r};
         `RPC_OFF_CDLY: rd_nxt = {4'h0, cdly_r};
         `RPC_OFF_DIVA: rd_nxt = {16'h0000, div_r[0]};
         `RPC_OFF_DIVB: rd_nxt = {16'h0000, div_r[1]};
         `RPC_OFF_STAT: rd_nxt = {27'h000_0000, tbusy_r[1], tbusy_r[0], ~run_r, ant_r};
         `RPC_OFF_IST:  rd_nxt = {28'h000_0000, ist_r};
         `RPC_OFF_IMSK: rd_nxt = {28'h000_0000, imsk_r};
         `RPC_OFF_TXA:  rd_nxt = 32'h0000_0000;
         `RPC_OFF_TXB:  rd_nxt = 32'h0000_0000;
         `RPC_OFF_RXA:  rd_nxt = {24'h00_0000, rx_data_r[0]};
         `RPC_OFF_RXB:  rd_nxt = {24'h00_0000, rx_data_r[1]};
         `RPC_OFF_SECS: rd_nxt = secs_r;
         default:       rd_hit = 1'b0;
      endcase
   end

   // One read in flight; data held until taken
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_nxt;
         s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Second counter; frozen in standby
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         sec_cnt_r <= 28'h000_0000;
      end else if (run_r) begin
         sec_cnt_r <= (sec_cnt_r == 28'(PERIOD - 1)) ? 28'h000_0000 : sec_cnt_r + 28'h1;
      end
   end

   // Window after the cable delay; a window past the second end is cut
   assign win_end  = {1'b0, cdly_r} + {1'b0, pw_r};
   assign pulse_en = run_r && (rpc_pmode_t'(ctrl_r[`RPC_CTRL_MODE +: 2]) == PM_ALWAYS ||
                     (rpc_pmode_t'(ctrl_r[`RPC_CTRL_MODE +: 2]) == PM_FIX_ONLY &&
                      ctrl_r[`RPC_CTRL_FIX]));
   assign act_nxt  = pulse_en && sec_cnt_r >= cdly_r && {1'b0, sec_cnt_r} < win_end;
   assign pulse_rise = act_nxt & ~act_r;

   // Pulse output registered, polarity applied last
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         act_r             <= 1'b0;
         one_hz_time_pulse <= 1'b0;
         secs_r            <= 32'h0000_0000;
      end else begin
         act_r             <= act_nxt;
         one_hz_time_pulse <= act_nxt ^ ctrl_r[`RPC_CTRL_POL];
         if (pulse_rise) begin
            secs_r <= secs_r + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Time report byte on port A; stale reports are dropped, not sent late
   assign rpt_go = rpt_pend_r & ~tbusy_r[0] & ~wr_tx[0];
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         rpt_pend_r <= 1'b0;
         rpt_age_r  <= 27'h000_0000;
      end else if (pulse_rise) begin
         rpt_pend_r <= 1'b1;
         rpt_age_r  <= 27'h000_0000;
      end else if (rpt_go || rpt_age_r == 27'(RPT_LIMIT - 1)) begin
         rpt_pend_r <= 1'b0;
      end else if (rpt_pend_r) begin
         rpt_age_r <= rpt_age_r + 27'h1;
      end
   end
   assign tx_load[0] = wr_tx[0] | rpt_go;
   assign tx_byte[0] = wr_tx[0] ? s_axi_wdata[7:0] : secs_r[7:0];
   assign tx_load[1] = wr_tx[1];
   assign tx_byte[1] = s_axi_wdata[7:0];

   ////////////////////////////////////////////////////////////////////
   // Serial ports: fixed 8N1 framing, divisor sets the baud
   for (genvar g = 0; g < 2; g++) begin : g_port
      // Transmitter; a byte written while busy is dropped
      always_ff @(posedge clk or negedge rst_core_b) begin
         if (!rst_core_b) begin
            tsh_r[g]   <= 10'h3FF;
            tbit_r[g]  <= 4'h0;
            tcnt_r[g]  <= 16'h0000;
            tbusy_r[g] <= 1'b0;
         end else if (!tbusy_r[g]) begin
            if (tx_load[g]) begin
               tsh_r[g]   <= {1'b1, tx_byte[g], 1'b0};
               tbit_r[g]  <= 4'h0;
               tcnt_r[g]  <= 16'h0000;
               tbusy_r[g] <= 1'b1;
            end
         end else if (tcnt_r[g] == div_r[g] - 16'h1) begin
            tcnt_r[g] <= 16'h0000;
            tsh_r[g]  <= {1'b1, tsh_r[g][9:1]};
            tbit_r[g] <= tbit_r[g] + 4'h1;
            if (tbit_r[g] == 4'h9) begin
               tbusy_r[g] <= 1'b0;
            end
         end else begin
            tcnt_r[g] <= tcnt_r[g] + 16'h1;
         end
      end

      // Receiver; samples mid-bit, drops frames with a bad stop bit
      always_ff @(posedge clk or negedge rst_core_b) begin
         if (!rst_core_b) begin
            rxq_r[g]     <= 2'h3;
            rxs_r[g]     <= RX_IDLE;
            rcnt_r[g]    <= 16'h0000;
            rbit_r[g]    <= 3'h0;
            rsh_r[g]     <= 8'h00;
            rx_data_r[g] <= 8'h00;
            rx_evt_r[g]  <= 1'b0;
         end else begin
            rxq_r[g]    <= {rxq_r[g][0], (g == 0) ? rxd_a : rxd_b};
            rx_evt_r[g] <= 1'b0;
            rcnt_r[g]   <= rcnt_r[g] + 16'h1;
            case (rxs_r[g])
               RX_IDLE: begin
                  rcnt_r[g] <= 16'h0000;
                  if (!rxq_r[g][1]) begin
                     rxs_r[g] <= RX_START;
                  end
               end
               RX_START: begin
                  if (rcnt_r[g] == {1'b0, div_r[g][15:1]}) begin
                     rcnt_r[g] <= 16'h0000;
                     rbit_r[g] <= 3'h0;
                     rxs_r[g]  <= rxq_r[g][1] ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rcnt_r[g] == div_r[g] - 16'h1) begin
                     rcnt_r[g] <= 16'h0000;
                     rsh_r[g]  <= {rxq_r[g][1], rsh_r[g][7:1]};
                     rbit_r[g] <= rbit_r[g] + 3'h1;
                     if (rbit_r[g] == 3'h7) begin
                        rxs_r[g] <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rcnt_r[g] == div_r[g] - 16'h1) begin
                     rxs_r[g] <= RX_IDLE;
                     if (rxq_r[g][1]) begin
                        rx_data_r[g] <= rsh_r[g];
                        rx_evt_r[g]  <= 1'b1;
                     end
                  end
               end
               default: rxs_r[g] <= RX_IDLE;
            endcase
         end
      end
   end
   assign txd_a = tsh_r[0][0];
   assign txd_b = tsh_r[1][0];

   ////////////////////////////////////////////////////////////////////
   // Sticky events; a set in the clear cycle survives
   assign ist_set = {ant_nxt != ant_r, rx_evt_r[1], rx_evt_r[0], pulse_rise};
   always_ff @(posedge clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
         ist_r <= 4'h0;
         irq   <= 1'b0;
      end else begin
         ist_r <= (ist_r & ~ist_clr) | ist_set;
         irq   <= |(((ist_r & ~ist_clr) | ist_set) & imsk_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_core_b);

   chk_amp_off_run: assert property (run_q_r[1] |=> !ext_amp_power_off)
      else $error("amp power not on while running");
   chk_ant_normal_code: assert property (ovc_q_r[1] && !noc_q_r[1] |=> ant_r == ANT_NORMAL)
      else $error("antenna normal not decoded");
   chk_ant_open_code: assert property (ovc_q_r[1] && noc_q_r[1] |=> ant_r == ANT_OPEN)
      else $error("antenna open not decoded");
   // Enable or window changes move an edge on purpose, so those cycles are left out
   chk_pulse_at_delay: assert property ($rose(act_r) && $past(pulse_en, 2) &&
      $past(cdly_r, 2) == $past(cdly_r) && $past(pw_r, 2) == $past(pw_r)
      |-> $past(sec_cnt_r) == $past(cdly_r))
      else $error("pulse rose away from delay point");
   chk_pulse_width_end: assert property ($fell(act_r) && $past(pulse_en) &&
      $past(pw_r, 2) == $past(pw_r) && $past(cdly_r, 2) == $past(cdly_r)
      |-> {1'b0, $past(sec_cnt_r)} == $past(win_end))
      else $error("pulse width wrong");
   chk_standby_idle: assert property (!run_r ##1 !run_r |-> one_hz_time_pulse
      == $past(ctrl_r[`RPC_CTRL_POL]))
      else $error("pulse active in standby");
   chk_mode_off_quiet: assert property (rpc_pmode_t'(ctrl_r[`RPC_CTRL_MODE +: 2]) == PM_OFF
      |=> !act_r)
      else $error("pulse in off mode");
   chk_report_start_bit: assert property (rpt_go |=> tbusy_r[0] && !txd_a)
      else $error("time report not started");
   chk_tx_stop_bit: assert property ($fell(tbusy_r[0]) |-> txd_a ##1 txd_a)
      else $error("line not idle after stop bit");

   cov_pulse_rise: cover property ($rose(act_r));
   cov_report_sent: cover property (rpt_go ##1 tbusy_r[0]);
   cov_rx_byte: cover property (rx_evt_r[0]);
   cov_ant_short: cover property (ant_r == ANT_SHORT);
endmodule

/* tb/rpc_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Board-side serial peer: frames into the receive pin, decodes the transmit pin
module rpc_host_model (
   input  wire logic        clk,
   input  wire logic        txd,
   output logic             rxd,
   input  wire logic [15:0] div
);
   logic [7:0] last;
   int         n_rx;
   int         start_t;

   // Line idles high between frames
   initial begin
      rxd = 1'b1;
      n_rx = 0;
      start_t = 0;
   end

   // Start, eight bits LSB first, one stop bit
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (div) @(posedge clk);
      end
   endtask

   // Mid-bit sampling; a low stop bit means a broken frame, not counted
   always begin
      @(negedge txd);
      start_t = int'($time);
      repeat (div / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(negedge clk);
         last[i] = txd;
      end
      repeat (div) @(negedge clk);
      if (txd === 1'b1) n_rx++;
   end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "rpc_defines.svh"
module tb;
   import rpc_pkg::*;
   localparam int PER  = 2000;
   localparam int RPT  = 1000;
   localparam int DIV  = 16;
   localparam int HOLD = 100000 / 4;  // Reset pin low time in cycles
   localparam logic [7:0]  OFFS [6] = '{`RPC_OFF_CTRL, `RPC_OFF_PW, `RPC_OFF_CDLY,
                                       `RPC_OFF_DIVA, `RPC_OFF_DIVB, `RPC_OFF_IMSK};
   localparam logic [31:0] RSTV [6] = '{`RPC_CTRL_RST, `RPC_PW_CYC, 0, `RPC_DIV_A, `RPC_DIV_B, 0};
   localparam logic [1:0]  ANT_IN [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
   localparam rpc_ant_t    ANT_EX [4] = '{ANT_OPEN, ANT_SHORT, ANT_UNDEF, ANT_NORMAL};
   localparam logic [31:0] MODE_C [4] = '{32'h0000_0820, 32'h0000_0810, 32'h0000_0812,
                                         32'h0000_0800};
   localparam int          MODE_N [4] = '{0, 0, 1, 1};

   logic        clk, rst_b, hw_reset_n, run_not_sleep, ant_ovc_sense, ant_noc_sense;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        ext_amp_power_off, one_hz_time_pulse, rxd_a, txd_a, rxd_b, txd_b, irq;
   rpc_ant_t    ant_status;
   int          fails, compares;

   rpc_top #(.PERIOD(PER), .RPT_LIMIT(RPT)) DUT (
      .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .hw_reset_n, .run_not_sleep, .ant_ovc_sense, .ant_noc_sense, .ext_amp_power_off,
      .one_hz_time_pulse, .ant_status, .rxd_a, .txd_a, .rxd_b, .txd_b, .irq);
   rpc_host_model host_a (.clk, .txd(txd_a), .rxd(rxd_a), .div(16'(DIV)));
   rpc_host_model host_b (.clk, .txd(txd_b), .rxd(rxd_b), .div(16'(DIV)));

   ////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   always #2 clk = ~clk;

   // Hang guard, sized well past the full sequence
   initial begin
      repeat (70000) @(posedge clk);
      fails++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_ant(input string nm, input rpc_ant_t e, input rpc_ant_t g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   // Ready is sampled at the falling edge, where it is settled until the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ha, hw, ta, tw, bv;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk);
         ha = s_axi_awvalid & s_axi_awready & ~ta;
         hw = s_axi_wvalid & s_axi_wready & ~tw;
         @(posedge clk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         ta = ta | ha;
         tw = tw | hw;
      end while (!(ta && tw));
      do begin
         @(negedge clk);
         bv = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
      end while (bv !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, rv;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clk);
         ha = s_axi_arready;
         @(posedge clk);
      end while (ha !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge clk);
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
      end while (rv !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(nm, e, d & m);
   endtask

   // Skips a pulse in progress, then times the next active phase
   task automatic meas(input logic pol, output int rise, output int wid);
      @(negedge clk);
      while ((one_hz_time_pulse ^ pol) !== 1'b0) @(negedge clk);
      while ((one_hz_time_pulse ^ pol) !== 1'b1) @(negedge clk);
      rise = int'($time);
      wid = 0;
      while ((one_hz_time_pulse ^ pol) === 1'b1) begin
         wid++;
         @(negedge clk);
      end
   endtask

   task automatic count_rises(output int c);
      logic p;
      c = 0;
      @(negedge clk);
      p = one_hz_time_pulse;
      repeat (PER) begin
         @(negedge clk);
         if (one_hz_time_pulse === 1'b1 && p === 1'b0) c++;
         p = one_hz_time_pulse;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; starts in standby so the pulse counter holds still
   initial begin
      logic [31:0] d, s1;
      logic [1:0]  r;
      int          r1, r2, w, c;
      {clk, rst_b, run_not_sleep, ant_noc_sense} = '0;
      {hw_reset_n, ant_ovc_sense} = 2'b11;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("amp_off_sby", 1, {31'd0, ext_amp_power_off});
      rdc("stat_sby", `RPC_OFF_STAT, 32'h0000_0004, 32'h0000_0004);
      for (int i = 0; i < 6; i++) rdc("reset_val", OFFS[i], '1, RSTV[i]);
      rd(8'h40, d, r);
      chk("rresp_bad", 2, {30'd0, r});
      chk("rdata_bad", 0, d);
      wr(8'h40, 32'h1234_5678, r);
      chk("bresp_bad", 2, {30'd0, r});
      wr(`RPC_OFF_DIVA, DIV, r);
      wr(`RPC_OFF_DIVB, DIV, r);
      wr(`RPC_OFF_CDLY, 100, r);
      wr(`RPC_OFF_PW, 20, r);
      count_rises(c);
      chk("sby_pulses", 0, c);
      @(posedge clk);
      run_not_sleep <= 1'b1;
      repeat (6) @(negedge clk);
      chk("amp_off_run", 0, {31'd0, ext_amp_power_off});
      // Sense pins walk through every decode; changes are latched for the interrupt
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {ant_ovc_sense, ant_noc_sense} <= ANT_IN[i];
         repeat (6) @(negedge clk);
         chk_ant("ant", ANT_EX[i], ant_status);
      end
      chk("irq_masked", 0, {31'd0, irq});
      wr(`RPC_OFF_IMSK, 32'h0000_0008, r);
      @(negedge clk);
      chk("irq_set", 1, {31'd0, irq});
      wr(`RPC_OFF_IST, 32'h0000_0008, r);
      @(negedge clk);
      chk("irq_clr", 0, {31'd0, irq});
      rdc("ist_ant", `RPC_OFF_IST, 32'h0000_0008, 0);
      // Width, period, report, then delay shift
      meas(1'b0, r1, w);
      chk("width", 20, w);
      rd(`RPC_OFF_SECS, s1, r);
      meas(1'b0, r2, w);
      chk("period", PER * 4, r2 - r1);
      repeat (10 * DIV + 8) @(negedge clk);
      rd(`RPC_OFF_SECS, d, r);
      chk("secs", s1 + 1, d);
      chk("report", {24'd0, d[7:0]}, {24'd0, host_a.last});
      chk("rpt_lat", 1, {31'd0, host_a.start_t >= r2 && host_a.start_t - r2 <= RPT * 4});
      wr(`RPC_OFF_CDLY, 400, r);
      // A write landing inside the new window clips one pulse; skip it
      meas(1'b0, r2, w);
      meas(1'b0, r2, w);
      chk("width_dly", 20, w);
      chk("delay", 300, ((r2 - r1) / 4) % PER);
      wr(`RPC_OFF_CTRL, 32'h0000_0801, r);
      meas(1'b1, r2, w);
      chk("inv_width", 20, w);
      chk("inv_idle", 1, {31'd0, one_hz_time_pulse});
      for (int i = 0; i < 4; i++) begin
         wr(`RPC_OFF_CTRL, MODE_C[i], r);
         count_rises(c);
         chk("mode", MODE_N[i], c);
      end
      // Serial traffic both ways; data chosen so a bit-order swap shows
      wr(`RPC_OFF_TXB, 32'h0000_001E, r);
      repeat (10 * DIV + 8) @(negedge clk);
      chk("txb", 32'h0000_001E, {24'd0, host_b.last});
      chk("txb_frames", 1, host_b.n_rx);
      host_a.send_byte(8'h4D);
      repeat (4) @(posedge clk);
      rdc("rxa", `RPC_OFF_RXA, 32'h0000_00FF, 32'h0000_004D);
      rdc("ist_rx", `RPC_OFF_IST, 32'h0000_0002, 32'h0000_0002);
      host_b.send_byte(8'hB2);
      repeat (4) @(posedge clk);
      rdc("rxb", `RPC_OFF_RXB, 32'h0000_00FF, 32'h0000_00B2);
      rdc("ist_rxb", `RPC_OFF_IST, 32'h0000_0004, 32'h0000_0004);
      // Hardware reset pin restores defaults
      wr(`RPC_OFF_PW, 33, r);
      rdc("pw_set", `RPC_OFF_PW, '1, 33);
      @(posedge clk);
      hw_reset_n <= 1'b0;
      repeat (HOLD) @(posedge clk);
      @(negedge clk);
      chk("amp_off_rst", 1, {31'd0, ext_amp_power_off});
      @(posedge clk);
      hw_reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      rdc("pw_rst", `RPC_OFF_PW, '1, `RPC_PW_CYC);
      report_and_stop();
   end
endmodule
